// ### core/ctbar_bit_clock.sv
// Bit-rate enable divider for the temperature bus.
// Assumes speed_sel comes from a register on the same clock.
`timescale 1ns/1ps
module ctbar_bit_clock (
	input  wire logic       hclk,
	input  wire logic       hresetn,
	input  wire logic [1:0] speed_sel,
	output logic            bit_tick
);
	import ctbar_pkg::*;

	typedef struct packed {
		logic [15:0] count;
		logic        tick;
	} ctbar_div_state_t;

	ctbar_div_state_t state_reg;
	ctbar_div_state_t state_next;
	logic [15:0]      limit;

	always_comb begin
		case (speed_sel)
			SPEED_1M5:  limit = DIV_1M5;
			SPEED_750K: limit = DIV_750K;
			SPEED_375K: limit = DIV_375K;
			default:    limit = DIV_187K;
		endcase
		state_next      = state_reg;
		state_next.tick = 1'b0;
		if (state_reg.count >= limit - 16'h0001) begin
			state_next.count = 16'h0000;
			state_next.tick  = 1'b1;
		end else begin
			state_next.count = state_reg.count + 16'h0001;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg <= '0;
		end else begin
			state_reg <= state_next;
		end
	end

	assign bit_tick = state_reg.tick;

endmodule : ctbar_bit_clock

// ### core/ctbar_pkg.sv
// Constants shared by the temperature bus agent register bank.
// Assumes a single 125 MHz clock and one word per register on AHB-Lite.
package ctbar_pkg;

	localparam int unsigned AGENTS          = 4;
	localparam int unsigned ADDR_W          = 12;

	// Register indices; byte address is four times the index
	localparam logic [7:0]  IDX_CONFIG      = 8'hE0;
	localparam logic [7:0]  IDX_BASE1       = 8'hE1;
	localparam logic [7:0]  IDX_BASE2       = 8'hE2;
	localparam logic [7:0]  IDX_BASE3       = 8'hE3;
	localparam logic [7:0]  IDX_BASE4       = 8'hE4;
	localparam logic [7:0]  IDX_DOMAIN      = 8'hE5;
	localparam logic [7:0]  IDX_A4_LOW      = 8'hE6;
	localparam logic [7:0]  IDX_A4_HIGH     = 8'hE7;
	localparam logic [7:0]  IDX_FLAGS       = 8'hE8;

	// Field positions
	localparam int unsigned CFG_SEL_LSB     = 0;
	localparam int unsigned CFG_EN_LSB      = 4;
	localparam int unsigned DOM_MAX_BIT     = 1;
	localparam int unsigned DOM_EN_LSB      = 4;
	localparam int unsigned FLAG_SPEED_LSB  = 0;
	localparam int unsigned FLAG_BANK_BIT   = 3;
	localparam int unsigned FLAG_STAT_LSB   = 4;

	// Reset values
	localparam logic [7:0]  CONFIG_RST      = 8'h00;
	localparam logic [6:0]  BASE_RST        = 7'h48;
	localparam logic [7:0]  DOMAIN_RST      = 8'h00;
	localparam logic [7:0]  FLAGS_RST       = 8'h00;

	// Client bus address of agent 1; agents follow in order
	localparam logic [7:0]  CLIENT_ADDR_BASE = 8'h30;

	// Transactions remembered for the frame-check alert
	localparam int unsigned FCS_WINDOW      = 3;

	// Bus bit rates
	localparam int unsigned CLK_HZ          = 125_000_000;
	localparam int unsigned RATE_1M5_HZ     = 1_500_000;
	localparam int unsigned RATE_750K_HZ    = 750_000;
	localparam int unsigned RATE_375K_HZ    = 375_000;
	localparam int unsigned RATE_187K_HZ    = 187_000;
	localparam logic [15:0] DIV_1M5         = 16'(CLK_HZ / RATE_1M5_HZ);
	localparam logic [15:0] DIV_750K        = 16'(CLK_HZ / RATE_750K_HZ);
	localparam logic [15:0] DIV_375K        = 16'(CLK_HZ / RATE_375K_HZ);
	localparam logic [15:0] DIV_187K        = 16'(CLK_HZ / RATE_187K_HZ);

	localparam logic [1:0]  SPEED_1M5       = 2'h0;
	localparam logic [1:0]  SPEED_750K      = 2'h1;
	localparam logic [1:0]  SPEED_375K      = 2'h2;
	localparam logic [1:0]  SPEED_187K      = 2'h3;

	localparam logic [1:0]  HTRANS_NONSEQ   = 2'h2;

endpackage : ctbar_pkg

// ### core/ctbar_regs.sv
// Register bank of the temperature bus controller, AHB-Lite slave.
// Assumes the transaction engine runs on hclk and gives per-agent results.
//
// Decided for this implementation: the AHB-Lite register port.
`timescale 1ns/1ps
module ctbar_regs (
	input  wire logic                           hclk,
	input  wire logic                           hresetn,
	input  wire logic                           hsel,
	input  wire logic [ctbar_pkg::ADDR_W-1:0]   haddr,
	input  wire logic [1:0]                     htrans,
	input  wire logic                           hwrite,
	input  wire logic [2:0]                     hsize,
	input  wire logic [31:0]                    hwdata,
	input  wire logic                           hready,
	output logic                                hreadyout,
	output logic                                hresp,
	output logic      [31:0]                    hrdata,
	input  wire logic [3:0][15:0]               domain0_temp,
	input  wire logic [3:0][15:0]               domain1_temp,
	input  wire logic                           xact_done,
	input  wire logic [1:0]                     xact_agent,
	input  wire logic                           xact_fcs_bad,
	input  wire logic [3:0]                     agent_absent,
	output logic      [7:0]                     xact_client_addr,
	output logic      [3:0]                     agent_enable,
	output logic      [3:0]                     second_domain_en,
	output logic      [3:0]                     domain_select,
	output logic                                return_highest,
	output logic      [3:0][6:0]                base_temperature_reference,
	output logic      [1:0]                     speed_sel,
	output logic                                bit_tick
);
	import ctbar_pkg::*;

	typedef struct packed {
		logic [3:0]                   agent_en;
		logic [3:0]                   dom_sel;
		logic [3:0][6:0]              base;
		logic [3:0]                   dom_en;
		logic                         ret_max;
		logic                         bank;
		logic [1:0]                   speed;
		logic [3:0][FCS_WINDOW-1:0]   hist;
		logic [3:0]                   absent;
		logic [3:0][15:0]             rel;
		logic [7:0]                   client_addr;
		logic                         wr_pend;
		logic [7:0]                   wr_idx;
		logic [31:0]                  rdata;
		logic                         ready;
		logic                         resp;
	} ctbar_state_t;

	ctbar_state_t     state_reg;
	ctbar_state_t     state_next;
	logic [3:0][15:0] reported_temp;
	logic             addr_ok;
	logic [7:0]       addr_idx;

	// Word-aligned address inside the bank window
	function automatic logic decode_ok(input logic [ADDR_W-1:0] a);
		decode_ok = (a[1:0] == 2'h0) && (a[ADDR_W-1:10] == '0);
	endfunction : decode_ok

	function automatic logic [7:0] decode_idx(input logic [ADDR_W-1:0] a);
		decode_idx = a[9:2];
	endfunction : decode_idx

	// Frame-check alert per agent: any bad frame in the window
	function automatic logic [3:0] alerts(input ctbar_state_t s);
		for (int i = 0; i < AGENTS; i++) begin
			alerts[i] = |s.hist[i];
		end
	endfunction : alerts

	function automatic logic [7:0] read_byte(input ctbar_state_t s, input logic [7:0] idx);
		logic b;
		b = s.bank;
		case (idx)
			IDX_CONFIG:  read_byte = b ? s.rel[0][7:0]  : {s.agent_en, s.dom_sel};
			IDX_BASE1:   read_byte = b ? s.rel[0][15:8] : {1'b0, s.base[0]};
			IDX_BASE2:   read_byte = b ? s.rel[1][7:0]  : {1'b0, s.base[1]};
			IDX_BASE3:   read_byte = b ? s.rel[1][15:8] : {1'b0, s.base[2]};
			IDX_BASE4:   read_byte = b ? s.rel[2][7:0]  : {1'b0, s.base[3]};
			IDX_DOMAIN:  read_byte = b ? s.rel[2][15:8]
				: {s.dom_en, 2'h0, s.ret_max, 1'b0};
			IDX_A4_LOW:  read_byte = b ? s.rel[3][7:0]  : 8'h00;
			IDX_A4_HIGH: read_byte = b ? s.rel[3][15:8] : 8'h00;
			IDX_FLAGS:   read_byte = {(b ? s.absent : alerts(s)), b, 1'b0, s.speed};
			default:     read_byte = 8'h00;
		endcase
	endfunction : read_byte

	ctbar_temp_select u_temp_select (
		.domain0_temp     (domain0_temp),
		.domain1_temp     (domain1_temp),
		.second_domain_en (state_reg.dom_en),
		.domain_select    (state_reg.dom_sel),
		.return_highest   (state_reg.ret_max),
		.reported_temp    (reported_temp)
	);

	ctbar_bit_clock u_bit_clock (
		.hclk      (hclk),
		.hresetn   (hresetn),
		.speed_sel (state_reg.speed),
		.bit_tick  (bit_tick)
	);

	assign addr_ok  = decode_ok(haddr);
	assign addr_idx = decode_idx(haddr);

	always_comb begin
		state_next       = state_reg;
		state_next.ready = 1'b1;
		state_next.resp  = 1'b0;

		// Data phase of a write; the bank seen is the one stored before it
		if (state_reg.wr_pend) begin
			case (state_reg.wr_idx)
				IDX_CONFIG: begin
					if (!state_reg.bank) begin
						state_next.agent_en = hwdata[CFG_EN_LSB +: 4];
						state_next.dom_sel  = hwdata[CFG_SEL_LSB +: 4];
					end
				end
				IDX_BASE1: begin
					if (!state_reg.bank) begin
						state_next.base[0] = hwdata[6:0];
					end
				end
				IDX_BASE2: begin
					if (!state_reg.bank) begin
						state_next.base[1] = hwdata[6:0];
					end
				end
				IDX_BASE3: begin
					if (!state_reg.bank) begin
						state_next.base[2] = hwdata[6:0];
					end
				end
				IDX_BASE4: begin
					if (!state_reg.bank) begin
						state_next.base[3] = hwdata[6:0];
					end
				end
				IDX_DOMAIN: begin
					if (!state_reg.bank) begin
						state_next.dom_en  = hwdata[DOM_EN_LSB +: 4];
						state_next.ret_max = hwdata[DOM_MAX_BIT];
					end
				end
				IDX_FLAGS: begin
					// Status bits 7-4 are driven by the engine, writes ignored
					state_next.bank  = hwdata[FLAG_BANK_BIT];
					state_next.speed = hwdata[FLAG_SPEED_LSB +: 2];
				end
				default: begin
				end
			endcase
		end
		state_next.wr_pend = 1'b0;

		// Engine results
		state_next.absent = agent_absent;
		if (xact_done) begin
			state_next.hist[xact_agent] =
				{state_reg.hist[xact_agent][FCS_WINDOW-2:0], xact_fcs_bad};
		end
		state_next.rel         = reported_temp;
		state_next.client_addr = CLIENT_ADDR_BASE + {6'h00, xact_agent};

		// Address phase
		if (hsel && hready && (htrans == HTRANS_NONSEQ)) begin
			if (hwrite) begin
				state_next.wr_pend = addr_ok;
				state_next.wr_idx  = addr_idx;
			end else begin
				// Read from next state so a write just ahead is seen
				state_next.rdata = addr_ok ? {24'h000000, read_byte(state_next, addr_idx)}
					: 32'h00000000;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_reg             <= '0;
			state_reg.agent_en    <= CONFIG_RST[CFG_EN_LSB +: 4];
			state_reg.dom_sel     <= CONFIG_RST[CFG_SEL_LSB +: 4];
			state_reg.base        <= {4{BASE_RST}};
			state_reg.dom_en      <= DOMAIN_RST[DOM_EN_LSB +: 4];
			state_reg.ret_max     <= DOMAIN_RST[DOM_MAX_BIT];
			state_reg.bank        <= FLAGS_RST[FLAG_BANK_BIT];
			state_reg.speed       <= FLAGS_RST[FLAG_SPEED_LSB +: 2];
			state_reg.client_addr <= CLIENT_ADDR_BASE;
			state_reg.ready       <= 1'b1;
		end else begin
			state_reg <= state_next;
		end
	end

	assign hreadyout                  = state_reg.ready;
	assign hresp                      = state_reg.resp;
	assign hrdata                     = state_reg.rdata;
	assign xact_client_addr           = state_reg.client_addr;
	assign agent_enable               = state_reg.agent_en;
	assign second_domain_en           = state_reg.dom_en;
	assign domain_select              = state_reg.dom_sel;
	assign return_highest             = state_reg.ret_max;
	assign base_temperature_reference = state_reg.base;
	assign speed_sel                  = state_reg.speed;

endmodule : ctbar_regs

// ### core/ctbar_temp_select.sv
// Per-agent choice of the reported relative temperature.
// Assumes temperatures are signed two's complement words.
`timescale 1ns/1ps
module ctbar_temp_select (
	input  wire logic [3:0][15:0] domain0_temp,
	input  wire logic [3:0][15:0] domain1_temp,
	input  wire logic [3:0]       second_domain_en,
	input  wire logic [3:0]       domain_select,
	input  wire logic             return_highest,
	output logic      [3:0][15:0] reported_temp
);
	import ctbar_pkg::*;

	always_comb begin
		for (int i = 0; i < AGENTS; i++) begin
			reported_temp[i] = domain0_temp[i];
			if (second_domain_en[i]) begin
				if (return_highest) begin
					// Higher of the two domains, signed compare
					if ($signed(domain1_temp[i]) > $signed(domain0_temp[i])) begin
						reported_temp[i] = domain1_temp[i];
					end
				end else if (domain_select[i]) begin
					reported_temp[i] = domain1_temp[i];
				end
			end
		end
	end

endmodule : ctbar_temp_select

// ### sim/ctbar_agent_model.sv
// Behavioural client agents behind the bus transaction engine.
// Assumes the bench calls load and xact from one thread.
`timescale 1ns/1ps
module ctbar_agent_model (
	input wire logic		hclk,
	output logic [3:0][15:0]	domain0_temp,
	output logic [3:0][15:0]	domain1_temp,
	output logic			xact_done,
	output logic [1:0]		xact_agent,
	output logic			xact_fcs_bad,
	output logic [3:0]		agent_absent
);
	initial begin
		domain0_temp = '0;
		domain1_temp = '0;
		xact_done = 1'b0;
		xact_agent = 2'h0;
		xact_fcs_bad = 1'b0;
		agent_absent = 4'h0;
	end
	task automatic load(input logic [3:0][15:0] d0, input logic [3:0][15:0] d1,
			input logic [3:0] gone);
		@(posedge hclk);
		domain0_temp <= d0;
		domain1_temp <= d1;
		agent_absent <= gone;
	endtask : load
	// Outside a result the agent and check lines carry junk
	task automatic xact(input logic [1:0] agent, input logic bad);
		@(posedge hclk);
		xact_done <= 1'b1;
		xact_agent <= agent;
		xact_fcs_bad <= bad;
		@(posedge hclk);
		xact_done <= 1'b0;
		xact_agent <= agent + 2'h1;
		xact_fcs_bad <= !bad;
	endtask : xact
endmodule : ctbar_agent_model

// ### sim/ctbar_regs_checker.sv
// Port assertions for the temperature bus register bank.
// Assumes zero-wait single-word AHB-Lite transfers on hclk.
`timescale 1ns/1ps
module ctbar_regs_checker (
	input wire logic				hclk,
	input wire logic				hresetn,
	input wire logic				hsel,
	input wire logic [ctbar_pkg::ADDR_W-1:0]	haddr,
	input wire logic [1:0]			htrans,
	input wire logic				hwrite,
	input wire logic [31:0]			hwdata,
	input wire logic				hready,
	input wire logic				hreadyout,
	input wire logic				hresp,
	input wire logic [1:0]			xact_agent,
	input wire logic [7:0]			xact_client_addr,
	input wire logic [3:0]			agent_enable,
	input wire logic [3:0]			second_domain_en,
	input wire logic [3:0]			domain_select,
	input wire logic				return_highest,
	input wire logic [1:0]			speed_sel,
	input wire logic				bit_tick
);
	import ctbar_pkg::*;
	logic		wr_reg;
	logic [7:0]	idx_reg;
	logic		bank_reg;
	logic [1:0]	spd_reg;
	logic		ok_reg;
	logic [9:0]	cnt_reg;
	logic [9:0]	div;
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	always_comb begin
		// Speed of the interval just ended, so a tick launched before a change uses the old rate
		case (spd_reg)
			SPEED_1M5:	div = DIV_1M5[9:0];
			SPEED_750K:	div = DIV_750K[9:0];
			SPEED_375K:	div = DIV_375K[9:0];
			default:	div = DIV_187K[9:0];
		endcase
	end
	// Data-phase write tracker; tick interval valid only after an unchanged-speed tick
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_reg <= 1'b0;
			idx_reg <= 8'h00;
			bank_reg <= 1'b0;
			spd_reg <= 2'h0;
			ok_reg <= 1'b0;
			cnt_reg <= 10'h000;
		end else begin
			wr_reg <= hsel && hready && htrans == HTRANS_NONSEQ && hwrite
				&& haddr[11:10] == 2'h0 && haddr[1:0] == 2'h0;
			idx_reg <= haddr[9:2];
			if (wr_reg && idx_reg == IDX_FLAGS)
				bank_reg <= hwdata[FLAG_BANK_BIT];
			spd_reg <= speed_sel;
			ok_reg <= (speed_sel == spd_reg) && (bit_tick || ok_reg);
			cnt_reg <= bit_tick ? 10'h000 : cnt_reg + 10'h001;
		end
	end
	ready_always_a: assert property (hreadyout && !hresp)
		else $error("bus not ready or not okay");
	client_addr_a: assert property (1'b1 |=>
		xact_client_addr == CLIENT_ADDR_BASE + 8'($past(xact_agent)))
		else $error("client address wrong");
	dom_write_a: assert property (wr_reg && idx_reg == IDX_DOMAIN && !bank_reg |=>
		second_domain_en == $past(hwdata[7:4])) else $error("domain enables wrong");
	ret_max_a: assert property (wr_reg && idx_reg == IDX_DOMAIN && !bank_reg |=>
		return_highest == $past(hwdata[1])) else $error("return highest wrong");
	cfg_write_a: assert property (wr_reg && idx_reg == IDX_CONFIG && !bank_reg |=>
		{agent_enable, domain_select} == $past(hwdata[7:0])) else $error("config wrong");
	speed_write_a: assert property (wr_reg && idx_reg == IDX_FLAGS |=>
		speed_sel == $past(hwdata[1:0])) else $error("speed wrong");
	hidden_keep_a: assert property (wr_reg && bank_reg && idx_reg <= IDX_DOMAIN |=>
		$stable(agent_enable) && $stable(domain_select) && $stable(second_domain_en))
		else $error("hidden config changed");
	tick_rate_a: assert property (bit_tick && ok_reg |-> cnt_reg == div - 10'h001)
		else $error("bit tick spacing wrong");
	bank_view_c: cover property (wr_reg && idx_reg == IDX_FLAGS && hwdata[FLAG_BANK_BIT]);
	slow_tick_c: cover property (bit_tick && ok_reg && speed_sel == SPEED_187K);
	hidden_c: cover property (wr_reg && bank_reg && idx_reg == IDX_CONFIG);
endmodule : ctbar_regs_checker

bind ctbar_regs ctbar_regs_checker u_ctbar_regs_checker (.hclk, .hresetn, .hsel, .haddr,
	.htrans, .hwrite, .hwdata, .hready, .hreadyout, .hresp, .xact_agent, .xact_client_addr,
	.agent_enable, .second_domain_en, .domain_select, .return_highest, .speed_sel, .bit_tick);

// ### sim/tb.sv
// Self-checking bench for the temperature bus register bank.
// Assumes a zero-wait slave; the agent model drives the engine side.
`timescale 1ns/1ps
module tb;
	import ctbar_pkg::*;
	logic			hclk, hresetn, hsel, hwrite, hready, hresp, return_highest, bit_tick;
	logic			xact_done, xact_fcs_bad;
	logic [ADDR_W-1:0]	haddr;
	logic [1:0]		htrans, xact_agent, speed_sel;
	logic [2:0]		hsize;
	logic [31:0]		hwdata, hrdata;
	logic [3:0][15:0]	domain0_temp, domain1_temp, d0, d1;
	logic [3:0]		agent_absent, agent_enable, second_domain_en, domain_select;
	logic [31:0]		rd;
	logic [15:0]		t;
	logic [3:0][6:0]	base_ref;
	int			fails, n_checks;
	ctbar_regs u_ctbar_regs (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
		.hready, .hreadyout(hready), .hresp, .hrdata, .domain0_temp, .domain1_temp, .xact_done,
		.xact_agent, .xact_fcs_bad, .agent_absent, .xact_client_addr(), .agent_enable,
		.second_domain_en, .domain_select, .return_highest, .base_temperature_reference(base_ref),
		.speed_sel, .bit_tick);
	ctbar_agent_model u_ctbar_agent_model (.hclk, .domain0_temp, .domain1_temp, .xact_done,
		.xact_agent, .xact_fcs_bad, .agent_absent);
	initial begin
		hclk = 1'b0;
		forever #4 hclk = ~hclk;
	end
	task automatic report_and_stop();
		$display("checks %0d, mismatches %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : report_and_stop
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: got %h, want %h", $time, seen, exp);
		end
	endtask : check
	task automatic wait_rdy();
		int n;
		n = 0;
		do begin
			@(posedge hclk);
			n++;
		end while (hready !== 1'b1 && n < 20);
		if (hready !== 1'b1) begin
			fails++;
			report_and_stop();
		end
	endtask : wait_rdy
	task automatic bus(input logic wr, input logic [11:0] a, input logic [7:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= a;
		htrans <= HTRANS_NONSEQ;
		hwrite <= wr;
		wait_rdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, wd};
		wait_rdy();
		rd = hrdata;
	endtask : bus
	task automatic rdc(input logic [11:0] a, input logic [15:0] exp);
		bus(1'b0, a, 8'h00);
		// Upper lanes must read zero, folded into the high byte
		check({rd[15:8] | rd[23:16] | rd[31:24], rd[7:0]}, exp);
	endtask : rdc
	function automatic logic [11:0] ad(input logic [7:0] i);
		return {2'b00, i, 2'b00};
	endfunction : ad
	function automatic logic [15:0] rep(input int i, input logic mx, input logic [3:0] en,
			input logic [3:0] sel);
		if (en[i] && mx)
			return ($signed(d0[i]) > $signed(d1[i])) ? d0[i] : d1[i];
		return (en[i] && sel[i]) ? d1[i] : d0[i];
	endfunction : rep
	initial begin
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = '0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = '0;
		fails = 0;
		n_checks = 0;
		repeat (5) @(posedge hclk);
		hresetn <= 1'b1;
		for (int i = 0; i < 9; i++)
			rdc(ad(IDX_CONFIG + 8'(i)), (i inside {[1:4]}) ? 16'(BASE_RST) : 16'h0000);
		bus(1'b1, ad(IDX_CONFIG), 8'hA5);
		rdc(ad(IDX_CONFIG), 16'h00A5);
		check(16'({agent_enable, domain_select}), 16'h00A5);
		bus(1'b1, ad(IDX_DOMAIN), 8'hF3);
		rdc(ad(IDX_DOMAIN), 16'h00F2);
		check(16'({second_domain_en, return_highest}), 16'h001F);
		bus(1'b1, ad(IDX_A4_LOW), 8'hFF);
		rdc(ad(IDX_A4_LOW), 16'h0000);
		bus(1'b1, 12'h3A4, 8'hFF);
		rdc(12'h3A4, 16'h0000);
		// Misaligned and out-of-window accesses are refused
		bus(1'b1, 12'h381, 8'h00);
		bus(1'b1, 12'h780, 8'h00);
		rdc(12'h780, 16'h0000);
		rdc(12'h381, 16'h0000);
		rdc(ad(IDX_CONFIG), 16'h00A5);
		bus(1'b1, ad(IDX_BASE1), 8'h95);
		rdc(ad(IDX_BASE1), 16'h0015);
		check(16'(base_ref[0]), 16'h0015);
		check(16'(base_ref[1]), 16'(BASE_RST));
		for (int s = 0; s < 4; s++) begin
			bus(1'b1, ad(IDX_FLAGS), 8'hF4 | 8'(s));
			rdc(ad(IDX_FLAGS), 16'(s));
			check(16'(speed_sel), 16'(s));
			repeat (1400) @(posedge hclk);
		end
		bus(1'b1, ad(IDX_FLAGS), 8'h00);
		u_ctbar_agent_model.xact(2'd3, 1'b1);
		u_ctbar_agent_model.xact(2'd2, 1'b1);
		for (int k = 0; k < 3; k++) begin
			rdc(ad(IDX_FLAGS), 16'h00C0);
			u_ctbar_agent_model.xact(2'd2, 1'b0);
		end
		rdc(ad(IDX_FLAGS), 16'h0080);
		d0 = {16'h0305, 16'hFE00, 16'h0100, 16'h0010};
		d1 = {16'h0001, 16'hFF00, 16'h0200, 16'hFFF0};
		u_ctbar_agent_model.load(d0, d1, 4'hA);
		for (int p = 0; p < 2; p++) begin
			bus(1'b1, ad(IDX_FLAGS), 8'h08);
			rdc(ad(IDX_FLAGS), 16'h00A8);
			for (int i = 0; i < 4; i++) begin
				t = rep(i, p == 0, p == 0 ? 4'hF : 4'h5, p == 0 ? 4'h5 : 4'hF);
				rdc(ad(IDX_CONFIG + 8'(2 * i)), {8'h00, t[7:0]});
				rdc(ad(IDX_BASE1 + 8'(2 * i)), {8'h00, t[15:8]});
			end
			bus(1'b1, ad(IDX_CONFIG), 8'hFF);
			bus(1'b1, ad(IDX_BASE1), 8'h00);
			bus(1'b1, ad(IDX_FLAGS), 8'h00);
			rdc(ad(IDX_CONFIG), p == 0 ? 16'h00A5 : 16'h000F);
			check(16'(base_ref[0]), 16'h0015);
			bus(1'b1, ad(IDX_CONFIG), 8'h0F);
			bus(1'b1, ad(IDX_DOMAIN), 8'h50);
		end
		report_and_stop();
	end
endmodule : tb
